/* File: logic/pco_pkg.sv */
// shared constants, register map and bus carriers for the clock output control block
package pco_pkg;

  // clock rates in kHz, used to scale the pll model onto pclk, and the pclk period in ns
  localparam int unsigned PCLK_KHZ = 40000;
  localparam int unsigned XTAL_KHZ = 27120;
  localparam int unsigned PCLK_PERIOD_NS = 25;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TRIM = 8'h3C;
  localparam logic [7:0] IDX_CTRL = 8'h3D;
  localparam logic [7:0] IDX_DIV = 8'h3E;
  localparam logic [7:0] IDX_PIN_IO = 8'h50;
  localparam logic [11:0] ADDR_TRIM = {2'h0, IDX_TRIM, 2'h0};
  localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_DIV = {2'h0, IDX_DIV, 2'h0};
  localparam logic [11:0] ADDR_PIN_IO = {2'h0, IDX_PIN_IO, 2'h0};

  // control register fields
  localparam int unsigned CTRL_SEL_LSB = 4;
  localparam int unsigned CTRL_EN_BIT = 3;
  localparam int unsigned CTRL_PD_BIT = 2;
  localparam int unsigned CTRL_FB_LSB = 0;

  // pin i/o register fields
  localparam int unsigned PIO_OUT_BIT = 0;
  localparam int unsigned PIO_OE_BIT = 1;
  localparam int unsigned PIO_IN_BIT = 2;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h08;
  localparam logic [7:0] TRIM_RST = 8'h80;

  // clock pin source codes
  localparam logic [3:0] SEL_GPIO = 4'h0;
  localparam logic [3:0] SEL_PLL = 4'h1;
  localparam logic [3:0] SEL_LOW = 4'h2;
  localparam logic [3:0] SEL_HIGH = 4'h3;
  localparam logic [3:0] SEL_XTAL_DIV1 = 4'h4;
  localparam logic [3:0] SEL_XTAL_DIV2 = 4'h5;
  localparam logic [3:0] SEL_XTAL_DIV4 = 4'h6;
  localparam logic [3:0] SEL_XTAL_DIV8 = 4'h7;
  localparam logic [3:0] SEL_TIMER_ZERO = 4'h8;
  localparam logic [3:0] SEL_TIMER3 = 4'hB;

  // feedback factors and output divider floor
  localparam logic [4:0] FB_MULT_A = 5'h17;
  localparam logic [4:0] FB_MULT_B = 5'h1B;
  localparam logic [4:0] FB_MULT_C = 5'h1C;
  localparam logic [7:0] DIV_MIN = 8'h08;

  // slow oscillator model: base period plus one cycle per trim step
  localparam int unsigned SLOW_BASE_NS = 6400;
  localparam logic [15:0] SLOW_BASE_CYC = 16'((SLOW_BASE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS);

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pco_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pco_apb_rsp_t;

  // feedback field to multiplication factor
  function automatic logic [4:0] pco_fb_mult(input logic [1:0] code);
    case (code)
      2'h1: pco_fb_mult = FB_MULT_B;
      2'h2: pco_fb_mult = FB_MULT_C;
      default: pco_fb_mult = FB_MULT_A;
    endcase
  endfunction

  // sources that hold a constant level
  function automatic logic pco_is_static(input logic [3:0] sel);
    pco_is_static = (sel == SEL_LOW) || (sel == SEL_HIGH) || (sel == SEL_GPIO);
  endfunction

endpackage

/* File: logic/pco_pin_switch.sv */
// glitch-free source switch for the clock output pin
module pco_pin_switch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] sel,
  input wire logic en,
  input wire logic [15:0] src,
  output logic pin
);
  import pco_pkg::*;

  typedef enum logic {
    SW_FOLLOW = 1'b0,
    SW_PARK = 1'b1
  } pco_sw_state_t;

  typedef struct packed {
    pco_sw_state_t state;
    logic [3:0] cur_sel;
    logic cur_en;
    logic pin;
  } pco_sw_t;

  pco_sw_t s_reg;
  pco_sw_t s_next;
  logic cur_lvl;
  logic new_lvl;
  logic change;

  assign cur_lvl = s_reg.cur_en & src[s_reg.cur_sel];
  assign new_lvl = en & src[sel];
  assign change = (sel != s_reg.cur_sel) || (en != s_reg.cur_en);

  // leave a source only while it is low or constant, park low, join the new one only while it is low or constant
  always_comb begin
    s_next = s_reg;
    case (s_reg.state)
      SW_FOLLOW: begin
        if (change && (!cur_lvl || pco_is_static(s_reg.cur_sel))) begin // [R13]
          s_next.state = SW_PARK;
          s_next.cur_sel = sel;
          s_next.cur_en = en;
          s_next.pin = 1'b0;
        end else begin
          s_next.pin = cur_lvl; // [R11]
        end
      end
      SW_PARK: begin
        s_next.pin = 1'b0;
        s_next.cur_sel = sel;
        s_next.cur_en = en;
        if (!new_lvl || pco_is_static(sel)) begin // [R13]
          s_next.state = SW_FOLLOW;
        end
      end
      default: begin
        s_next.state = SW_PARK;
        s_next.pin = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{state: SW_FOLLOW, cur_sel: SEL_GPIO, cur_en: 1'b0, pin: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin = s_reg.pin;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_park_low;
    s_reg.state == SW_PARK |-> s_reg.pin == 1'b0;
  endproperty
  a_park_low: assert property (p_park_low) else $error("pin not low while parked"); // [R13]

  property p_pll_route;
    (s_reg.state == SW_FOLLOW && s_reg.cur_sel == SEL_PLL && s_reg.cur_en && !change)
      |=> s_reg.pin == $past(src[1]);
  endproperty
  a_pll_route: assert property (p_pll_route) else $error("pll clock not routed to pin"); // [R7]

endmodule

/* File: logic/pco_clock_ctrl.sv */
// register file, pll model, crystal dividers and clock output pin control
// Summary of operation
// R1 - eight-bit trim; larger value, slower oscillator
// R2 - stage one: crystal times factor, halved
// R3 - stage two: divide by output divider value
// R4 - feedback code 0,1,2,3 gives 23,27,28,23
// R5 - output divider 8..254; 0..7 never programmed
// R6 - select 0 makes pin general I/O
// R7 - select 1 routes pll clock to pin
// R8 - select 2 holds low, 3 holds high
// R9 - selects 4..7 give crystal over 1,2,4,8
// R10 - selects 8..B toggle on timer overflows
// R11 - enable bit gates clock onto pin
// R12 - power-down stops pll output toggling
// R13 - source changes switch glitch-free, no runts
//
// Design decision made here: the APB register port.
module pco_clock_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire pco_pkg::pco_apb_req_t apb_req,
  output pco_pkg::pco_apb_rsp_t apb_rsp,
  input wire logic xtal_clk,
  input wire logic [3:0] timer_overflow,
  input wire logic clock_output_pin_i,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  output logic [7:0] slow_osc_trim_value,
  output logic slow_osc_tick,
  output logic pll_power_down
);
  import pco_pkg::*;

  localparam int unsigned ACC_W = 24;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] div;
    logic [7:0] trim;
    logic gpio_out;
    logic gpio_oe;
    logic [ACC_W-1:0] acc;
    logic pll_lvl;
    logic xtal_q;
    logic xtal_prev;
    logic [2:0] xcnt;
    logic [3:0] tmr_tgl;
    logic [15:0] slow_cnt;
    logic slow_tick;
    logic pin_o;
    logic pin_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pco_state_t;

  pco_state_t s_reg;
  pco_state_t s_next;

  logic acc_phase;
  logic hit;
  logic do_write;
  logic [31:0] rd_data;
  logic [3:0] sel;
  logic pin_en;
  logic pd;
  logic [7:0] eff_div;
  logic [ACC_W-1:0] inc;
  logic [ACC_W-1:0] lim;
  logic [ACC_W:0] sum;
  logic [ACC_W:0] rem;
  logic [15:0] src;
  logic sw_pin;
  logic xtal_rise;

  // field views of the control register
  assign sel = s_reg.ctrl[CTRL_SEL_LSB +: 4];
  assign pin_en = s_reg.ctrl[CTRL_EN_BIT];
  assign pd = s_reg.ctrl[CTRL_PD_BIT];

  // apb decode; a single wait state lets every answer leave a flop
  assign acc_phase = apb_req.psel & apb_req.penable;
  assign hit = (apb_req.paddr == ADDR_TRIM) || (apb_req.paddr == ADDR_CTRL)
    || (apb_req.paddr == ADDR_DIV) || (apb_req.paddr == ADDR_PIN_IO);
  assign do_write = acc_phase & s_reg.pready & apb_req.pwrite & hit & apb_req.pstrb[0];

  // read mux; bits above each register read as zero
  always_comb begin
    rd_data = 32'h00000000;
    case (apb_req.paddr)
      ADDR_TRIM: rd_data[7:0] = s_reg.trim; // [R1]
      ADDR_CTRL: rd_data[7:0] = s_reg.ctrl;
      ADDR_DIV: rd_data[7:0] = s_reg.div;
      ADDR_PIN_IO: begin
        rd_data[PIO_OUT_BIT] = s_reg.gpio_out;
        rd_data[PIO_OE_BIT] = s_reg.gpio_oe;
        rd_data[PIO_IN_BIT] = clock_output_pin_i;
      end
      default: rd_data = 32'h00000000;
    endcase
  end

  // reserved divider settings are clamped so the model never runs faster than specified
  assign eff_div = (s_reg.div < DIV_MIN) ? DIV_MIN : s_reg.div; // [R5]

  // pll model as a rate accumulator: toggles at xtal*mult/div, i.e. output xtal*mult/2/div
  assign inc = ACC_W'(pco_fb_mult(s_reg.ctrl[CTRL_FB_LSB +: 2]) * XTAL_KHZ); // [R2] [R4]
  assign lim = ACC_W'(eff_div * PCLK_KHZ); // [R3]
  assign sum = {1'b0, s_reg.acc} + {1'b0, inc};
  assign rem = sum - {1'b0, lim};

  assign xtal_rise = s_reg.xtal_q & ~s_reg.xtal_prev;

  // candidate levels for the pin, indexed by source code
  always_comb begin
    src = 16'h0000;
    src[SEL_PLL] = s_reg.pll_lvl; // [R7]
    src[SEL_LOW] = 1'b0; // [R8]
    src[SEL_HIGH] = 1'b1; // [R8]
    src[SEL_XTAL_DIV1] = s_reg.xtal_q; // [R9]
    src[SEL_XTAL_DIV2] = s_reg.xcnt[0]; // [R9]
    src[SEL_XTAL_DIV4] = s_reg.xcnt[1]; // [R9]
    src[SEL_XTAL_DIV8] = s_reg.xcnt[2]; // [R9]
    src[SEL_TIMER_ZERO +: 4] = s_reg.tmr_tgl; // [R10]
  end

  pco_pin_switch u_switch (
    .pclk(pclk),
    .presetn(presetn),
    .sel(sel),
    .en(pin_en),
    .src(src),
    .pin(sw_pin)
  );

  // next-state logic for the whole block
  always_comb begin
    s_next = s_reg;

    // bus answer and register writes
    s_next.pready = acc_phase & ~s_reg.pready;
    s_next.prdata = 32'h00000000;
    s_next.pslverr = 1'b0;
    if (acc_phase && !s_reg.pready) begin
      s_next.prdata = apb_req.pwrite ? 32'h00000000 : rd_data;
      s_next.pslverr = ~hit;
    end
    if (do_write) begin
      case (apb_req.paddr)
        ADDR_TRIM: s_next.trim = apb_req.pwdata[7:0]; // [R1]
        ADDR_CTRL: s_next.ctrl = apb_req.pwdata[7:0];
        ADDR_DIV: s_next.div = apb_req.pwdata[7:0];
        ADDR_PIN_IO: begin
          s_next.gpio_out = apb_req.pwdata[PIO_OUT_BIT];
          s_next.gpio_oe = apb_req.pwdata[PIO_OE_BIT];
        end
        default: s_next.trim = s_reg.trim;
      endcase
    end

    // pll: held quiet in power-down; at most one toggle per pclk, a limit of the model
    if (pd) begin
      s_next.acc = '0; // [R12]
      s_next.pll_lvl = 1'b0; // [R12]
    end else if (sum >= {1'b0, lim}) begin
      s_next.pll_lvl = ~s_reg.pll_lvl; // [R3]
      s_next.acc = (rem >= {1'b0, lim}) ? '0 : rem[ACC_W-1:0];
    end else begin
      s_next.acc = sum[ACC_W-1:0]; // [R2]
    end

    // crystal ripple divider counts rising edges of the sampled crystal
    s_next.xtal_q = xtal_clk;
    s_next.xtal_prev = s_reg.xtal_q;
    if (xtal_rise) begin
      s_next.xcnt = s_reg.xcnt + 3'h1; // [R9]
    end

    // each timer overflow flips its own toggle
    s_next.tmr_tgl = s_reg.tmr_tgl ^ timer_overflow; // [R10]

    // slow oscillator model: more trim, longer period
    if (s_reg.slow_cnt == 16'h0000) begin
      s_next.slow_cnt = SLOW_BASE_CYC + {8'h00, s_reg.trim}; // [R1]
      s_next.slow_tick = 1'b1;
    end else begin
      s_next.slow_cnt = s_reg.slow_cnt - 16'h0001;
      s_next.slow_tick = 1'b0;
    end

    // pin: i/o mode bypasses the clock path entirely
    if (sel == SEL_GPIO) begin
      s_next.pin_o = s_reg.gpio_out; // [R6]
      s_next.pin_oe = s_reg.gpio_oe; // [R6]
    end else begin
      s_next.pin_o = sw_pin; // [R11]
      s_next.pin_oe = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{ctrl: CTRL_RST, div: DIV_RST, trim: TRIM_RST, gpio_out: 1'b0, gpio_oe: 1'b0,
                 acc: '0, pll_lvl: 1'b0, xtal_q: 1'b0, xtal_prev: 1'b0, xcnt: 3'h0,
                 tmr_tgl: 4'h0, slow_cnt: 16'h0000, slow_tick: 1'b0, pin_o: 1'b0, pin_oe: 1'b0,
                 prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign apb_rsp.prdata = s_reg.prdata;
  assign apb_rsp.pready = s_reg.pready;
  assign apb_rsp.pslverr = s_reg.pslverr;
  assign clock_output_pin_o = s_reg.pin_o;
  assign clock_output_pin_oe = s_reg.pin_oe;
  assign slow_osc_trim_value = s_reg.trim;
  assign slow_osc_tick = s_reg.slow_tick;
  assign pll_power_down = pd;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_trim_write;
    do_write && apb_req.paddr == ADDR_TRIM;
  endsequence

  property p_trim_store;
    logic [7:0] v;
    (s_trim_write, v = apb_req.pwdata[7:0]) |=> slow_osc_trim_value == v;
  endproperty
  a_trim_store: assert property (p_trim_store) else $error("trim value not stored"); // [R1]

  property p_trim_period;
    (s_reg.slow_cnt == 16'h0000 && !do_write)
      |=> s_reg.slow_cnt == SLOW_BASE_CYC + {8'h00, $past(s_reg.trim)};
  endproperty
  a_trim_period: assert property (p_trim_period) else $error("slow oscillator period not trim based"); // [R1]

  property p_fb_step;
    (!pd && sum < {1'b0, lim})
      |=> s_reg.acc == $past(s_reg.acc) + ACC_W'(pco_fb_mult($past(s_reg.ctrl[1:0])) * XTAL_KHZ);
  endproperty
  a_fb_step: assert property (p_fb_step) else $error("pll step not set by feedback factor"); // [R4]

  property p_div_floor;
    lim >= ACC_W'(DIV_MIN * PCLK_KHZ);
  endproperty
  a_div_floor: assert property (p_div_floor) else $error("output divider below floor"); // [R5]

  property p_gpio_mode;
    (sel == SEL_GPIO) |=> clock_output_pin_oe == $past(s_reg.gpio_oe)
      && clock_output_pin_o == $past(s_reg.gpio_out);
  endproperty
  a_gpio_mode: assert property (p_gpio_mode) else $error("pin not in i/o mode"); // [R6]

  sequence s_hold_high;
    (sel == SEL_HIGH && pin_en) [*6];
  endsequence

  property p_const_high;
    s_hold_high |-> clock_output_pin_o && clock_output_pin_oe;
  endproperty
  a_const_high: assert property (p_const_high) else $error("pin not held high"); // [R8]

  property p_xtal_div;
    xtal_rise |=> s_reg.xcnt == $past(s_reg.xcnt) + 3'h1;
  endproperty
  a_xtal_div: assert property (p_xtal_div) else $error("crystal divider missed an edge"); // [R9]

  property p_timer_toggle;
    timer_overflow[0] |=> s_reg.tmr_tgl[0] != $past(s_reg.tmr_tgl[0]);
  endproperty
  a_timer_toggle: assert property (p_timer_toggle) else $error("timer toggle missed"); // [R10]

  // a disabled clock may finish its high phase first, so only a settled low switch output counts
  property p_gate_off;
    (!pin_en && sel != SEL_GPIO && !sw_pin) [*2] |=> !clock_output_pin_o;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("clock on pin while disabled"); // [R11]

  property p_power_down;
    pd |=> !s_reg.pll_lvl ##1 (!s_reg.pll_lvl || !$past(pd));
  endproperty
  a_power_down: assert property (p_power_down) else $error("pll toggles in power-down"); // [R12]

  property p_ready_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

endmodule

/* File: tb/pll_clock_output_control_test.sv */
// self-checking bench for the clock output control block over apb
module pll_clock_output_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pco_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic xtal_clk = 1'b0;
  logic [1:0] xt_cnt = 2'h0;
  logic [3:0] timer_overflow = 4'h0;
  wire pin_i;
  logic pin_o;
  logic pin_oe;
  logic [7:0] trim_q;
  logic tick;
  logic pd_q;
  pco_apb_req_t req = '0;
  pco_apb_rsp_t rsp;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  int r;
  int p;
  real ex;
  int mult[4] = '{23, 27, 28, 23};

  pco_clock_ctrl pco_clock_ctrl_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .xtal_clk(xtal_clk), .timer_overflow(timer_overflow), .clock_output_pin_i(pin_i),
    .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe), .slow_osc_trim_value(trim_q),
    .slow_osc_tick(tick), .pll_power_down(pd_q));

  // 40 mhz bus clock
  always #12.5 pclk = ~pclk;

  // crystal slowed to 5 mhz and stepped on pclk so sampling it cannot alias
  always @(posedge pclk) begin
    xt_cnt <= xt_cnt + 2'h1;
    if (xt_cnt == 2'h3) xtal_clk <= ~xtal_clk;
  end

  // pin pad: pulled up whenever the block releases it
  assign pin_i = pin_oe ? pin_o : 1'b1;

  // hang guard, about half again the ~40k cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // one apb transfer: setup, access, hold until pready sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= 4'hF;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 1, 0);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr_ctrl(input logic [3:0] sel, input logic en, input logic pd, input logic [1:0] fb);
    apb(ADDR_CTRL, 1'b1, {24'h0, sel, en, pd, fb});
    repeat (10) @(posedge pclk);
  endtask

  // rising edges of the pin over a window of pclk cycles
  task automatic rises(input int n, output int c);
    logic prev;
    prev = pin_o;
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pin_o === 1'b1 && prev !== 1'b1) c++;
      prev = pin_o;
    end
  endtask

  // cycles between two slow oscillator ticks, the first one skipped
  task automatic tick_period(output int c);
    repeat (2) begin
      c = 0;
      do begin
        @(posedge pclk);
        c++;
      end while (tick !== 1'b1 && c < 2000);
    end
  endtask

  // pulse overflow lines and count every pin level change meanwhile
  task automatic pulse(input logic [3:0] m, input int k, output int c);
    logic prev;
    prev = pin_o;
    c = 0;
    repeat (k) begin
      timer_overflow <= m;
      @(posedge pclk);
      timer_overflow <= 4'h0;
      repeat (9) begin
        @(posedge pclk);
        if (pin_o !== prev) c++;
        prev = pin_o;
      end
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and read-back
    apb(ADDR_TRIM, 1'b0, 0);
    chk("trim_reset", 32'h80, rd);
    apb(ADDR_CTRL, 1'b0, 0);
    chk("ctrl_reset", 32'h00, rd);
    apb(ADDR_DIV, 1'b0, 0);
    chk("div_reset", 32'h08, rd);
    apb(12'h000, 1'b0, 0);
    chk("unmapped_err", 1, err);
    apb(ADDR_TRIM, 1'b1, 32'hA5);
    apb(ADDR_TRIM, 1'b0, 0);
    chk("trim_rw", 32'hA5, rd);
    chk("trim_port", 32'hA5, trim_q);
    // larger trim gives a longer tick period
    apb(ADDR_TRIM, 1'b1, 32'h00);
    tick_period(p);
    chk("tick_period_0", 257, p);
    apb(ADDR_TRIM, 1'b1, 32'h10);
    tick_period(p);
    chk("tick_period_10", 273, p);
    // general i/o use of the pin
    apb(ADDR_PIN_IO, 1'b1, 32'h03);
    repeat (4) @(posedge pclk);
    chk("gpio_o", 1, pin_o);
    chk("gpio_oe", 1, pin_oe);
    apb(ADDR_PIN_IO, 1'b0, 0);
    chk("gpio_read", 32'h07, rd);
    apb(ADDR_PIN_IO, 1'b1, 32'h00);
    repeat (4) @(posedge pclk);
    chk("gpio_off_oe", 0, pin_oe);
    apb(ADDR_PIN_IO, 1'b0, 0);
    chk("gpio_pullup_read", 32'h04, rd);
    // constant levels and the enable gate
    wr_ctrl(SEL_LOW, 1'b1, 1'b0, 2'h0);
    chk("low_o", 0, pin_o);
    chk("low_oe", 1, pin_oe);
    wr_ctrl(SEL_HIGH, 1'b1, 1'b0, 2'h0);
    chk("high_o", 1, pin_o);
    wr_ctrl(SEL_HIGH, 1'b0, 1'b0, 2'h0);
    chk("disabled_o", 0, pin_o);
    // crystal dividers 1, 2, 4, 8
    for (int k = 0; k < 4; k++) begin
      wr_ctrl(SEL_XTAL_DIV1 + 4'(k), 1'b1, 1'b0, 2'h0);
      rises(4000, r);
      chk_rng("xtal_div", (500 >> k) - 3, (500 >> k) + 3, r);
    end
    // pll: every feedback code at the top divider, then a mid divider
    apb(ADDR_DIV, 1'b1, 32'd254);
    for (int k = 0; k < 5; k++) begin
      if (k == 4) apb(ADDR_DIV, 1'b1, 32'd100);
      wr_ctrl(SEL_PLL, 1'b1, 1'b0, 2'(k % 4));
      rises(4000, r);
      ex = real'(XTAL_KHZ) * mult[k % 4] / (20.0 * ((k == 4) ? 100 : 254));
      chk_rng("pll_rate", int'(ex) - 3, int'(ex) + 3, r);
    end
    // power-down stops the pll clock
    wr_ctrl(SEL_PLL, 1'b1, 1'b1, 2'h0);
    chk("pd_port", 1, pd_q);
    rises(1000, r);
    chk("pd_rises", 0, r);
    // timer overflow toggling, other timers must not disturb the pin
    for (int t = 0; t < 4; t++) begin
      wr_ctrl(SEL_TIMER_ZERO + 4'(t), 1'b1, 1'b0, 2'h0);
      pulse(4'(1 << t), 8, r);
      chk("timer_toggle", 8, r);
      pulse(4'hF & ~4'(1 << t), 4, r);
      chk("timer_other", 0, r);
    end
    print_verdict();
  end
endmodule
